// [rtl/vsd_pkg.sv]
/*
  Shared constants and types of the VMEbus-side DMA and interrupt forwarding block.
  Assumes a 32-bit APB slave whose register index is paddr[7:2].
*/
package vsd_pkg;
  // ----------------------------------------
  // Register indices, byte address = 4 * index
  // ----------------------------------------
  localparam logic [5:0] IDX_LCMD   = 6'h01;
  localparam logic [5:0] IDX_LSTAT  = 6'h03;
  localparam logic [5:0] IDX_AMOD   = 6'h04;
  localparam logic [5:0] IDX_IVEC   = 6'h07;
  localparam logic [5:0] IDX_RCMD   = 6'h09;
  localparam logic [5:0] IDX_RSTAT  = 6'h0B;
  localparam logic [5:0] IDX_DCMD   = 6'h10;
  localparam logic [5:0] IDX_LDADDR = 6'h11;
  localparam logic [5:0] IDX_RDADDR = 6'h12;
  localparam logic [5:0] IDX_LREM   = 6'h13;
  localparam logic [5:0] IDX_RREM   = 6'h14;
  localparam logic [5:0] IDX_PKT    = 6'h15;
  localparam logic [5:0] IDX_FWD    = 6'h16;
  // ----------------------------------------
  // Bit positions
  // ----------------------------------------
  localparam int LCMD_DIS_VA  = 2;
  localparam int LCMD_DIS_AV  = 4;
  localparam int LCMD_SEND_PT = 5;
  localparam int LCMD_CLR_PR  = 6;
  localparam int LCMD_CLR_ERR = 7;
  localparam int LST_RBUS     = 2;
  localparam int LST_TMO      = 3;
  localparam int LST_PR       = 5;
  localparam int LST_LRC      = 6;
  localparam int LST_PAR      = 7;
  localparam int RCMD_SEND_PR = 5;
  localparam int RCMD_CLR_PT  = 6;
  localparam int RST_PT       = 1;
  localparam int DC_BLOCK     = 0;
  localparam int DC_DONE      = 1;
  localparam int DC_IEN       = 2;
  localparam int DC_PAUSE     = 3;
  localparam int DC_WRITE     = 4;
  localparam int DC_D64       = 5;
  localparam int DC_START     = 7;
  // ----------------------------------------
  // Transfer sizes in bytes; the packet size as a shift (256 bytes)
  // ----------------------------------------
  localparam logic [9:0] LIM_PAUSE = 10'h040;
  localparam logic [9:0] LIM_D32   = 10'h100;
  localparam logic [9:0] LIM_D64   = 10'h200;
  localparam logic [3:0] BEAT_D32  = 4'h4;
  localparam logic [3:0] BEAT_D64  = 4'h8;
  localparam int         PKT_SHIFT = 8;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic        d64;
  } vsd_vme_req_type;

  typedef struct packed {
    logic parity;
    logic longitudinal_redundancy_check;
    logic timeout;
    logic rbus;
  } vsd_err_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARB,
    ST_XFER,
    ST_REL
  } vsd_dma_state_type;
endpackage

// [rtl/vsd_sync3.sv]
/*
  Three-stage input synchroniser for pins from outside the pclk domain.
  Output follows only once the second and third stages agree.
*/
`timescale 1ns/100ps
module vsd_sync3 #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  if (W < 1) begin : g_bad_w
    $error("vsd_sync3: W must be at least 1");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Per-bit agreement so one noisy level cannot hold back the others
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout <= RST_VAL;
    end else begin
      dout <= (s2_r & s3_r) | (dout & (s2_r | s3_r));
    end
  end
endmodule

// [rtl/vsd_dma.sv]
/*
  VMEbus-side DMA controller with status flags and backplane interrupt forwarding.
  Assumes an APB master on pclk, VME master logic and cable logic on pclk,
  and backplane interrupt pins that are asynchronous and active low.
*/
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/100ps
module vsd_dma #(
  parameter int PKT_W = 16
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [7:1]               vme_irq_n,
  output logic      [7:1]               cable_interrupt_line,
  input  wire vsd_pkg::vsd_err_type     err_in,
  input  wire logic                     receiver_side_programmed_irq,
  input  wire logic                     transmitter_side_programmed_irq,
  output logic                          send_pt,
  output logic                          send_pr,
  output logic                          irq_err,
  output logic                          irq_pr,
  output logic                          irq_dma_done,
  output logic      [7:0]               addr_modifier,
  output logic      [7:0]               irq_vector,
  input  wire logic                     remote_dma_busy,
  output logic                          dma_busy,
  output logic                          vme_bus_req,
  input  wire logic                     vme_bus_grant,
  output logic                          vme_req_valid,
  output vsd_pkg::vsd_vme_req_type      vme_req,
  input  wire logic                     vme_ack,
  input  wire logic                     vme_err,
  output logic      [23:0]              remote_addr
);
  localparam int BL_W = PKT_W + vsd_pkg::PKT_SHIFT;

  if (PKT_W < 1 || PKT_W > 24) begin : g_bad_pkt_w
    $error("vsd_dma: PKT_W out of range");
  end

  // ----------------------------------------
  // Registers and wires
  // ----------------------------------------
  vsd_pkg::vsd_dma_state_type state_r;
  vsd_pkg::vsd_err_type       err_r;
  logic              dis_va_r;
  logic              dis_av_r;
  logic              pr_pend_r;
  logic              pt_pend_r;
  logic [7:1]        fwd_mask_r;
  logic [5:0]        dcmd_r;
  logic              done_r;
  logic [31:0]       ldaddr_r;
  logic [23:0]       rdaddr_r;
  logic [7:0]        lrem_r;
  logic [7:0]        rrem_r;
  logic [PKT_W-1:0]  pkt_r;
  logic [BL_W-1:0]   bytes_left_r;
  logic [9:0]        tenure_r;
  logic [7:1]        irq_lvl;
  logic [5:0]        idx;
  logic              wr;
  logic              mapped;
  logic              start;
  logic              finish;
  logic [3:0]        beat_full;
  logic [3:0]        beat;
  logic [9:0]        limit;
  logic              last_beat;
  logic              tenure_end;

  assign idx    = paddr[7:2];
  assign wr     = psel & penable & pwrite;
  assign pready = psel & penable;
  assign mapped = idx inside {vsd_pkg::IDX_LCMD, vsd_pkg::IDX_LSTAT, vsd_pkg::IDX_AMOD,
                              vsd_pkg::IDX_IVEC, vsd_pkg::IDX_RCMD, vsd_pkg::IDX_RSTAT,
                              vsd_pkg::IDX_DCMD, vsd_pkg::IDX_LDADDR, vsd_pkg::IDX_RDADDR,
                              vsd_pkg::IDX_LREM, vsd_pkg::IDX_RREM, vsd_pkg::IDX_PKT,
                              vsd_pkg::IDX_FWD};
  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------
  // Backplane interrupt forwarding
  // ----------------------------------------
  vsd_sync3 #(
    .W       (7),
    .RST_VAL (7'h7F)
  ) u_irq_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (vme_irq_n),
    .dout    (irq_lvl)
  );

  // Level n only ever reaches cable line n; mask excludes lines not selected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cable_interrupt_line <= 7'h00;
    end else begin
      cable_interrupt_line <= ~irq_lvl & fwd_mask_r & {7{~dis_va_r}};
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dis_va_r      <= 1'b0;
      dis_av_r      <= 1'b0;
      addr_modifier <= 8'h00;
      irq_vector    <= 8'h00;
      fwd_mask_r    <= 7'h00;
      ldaddr_r      <= 32'h0000_0000;
      rdaddr_r      <= 24'h00_0000;
      lrem_r        <= 8'h00;
      rrem_r        <= 8'h00;
      pkt_r         <= '0;
      dcmd_r        <= 6'h00;
    end else if (wr) begin
      unique case (idx)
        vsd_pkg::IDX_LCMD: begin
          dis_va_r <= pwdata[vsd_pkg::LCMD_DIS_VA];
          dis_av_r <= pwdata[vsd_pkg::LCMD_DIS_AV];
        end
        vsd_pkg::IDX_AMOD:   addr_modifier <= pwdata[7:0];
        vsd_pkg::IDX_IVEC:   irq_vector    <= pwdata[7:0];
        vsd_pkg::IDX_FWD:    fwd_mask_r    <= pwdata[7:1];
        vsd_pkg::IDX_LDADDR: ldaddr_r      <= pwdata;
        vsd_pkg::IDX_RDADDR: rdaddr_r      <= pwdata[23:0];
        vsd_pkg::IDX_LREM:   lrem_r        <= pwdata[7:0];
        vsd_pkg::IDX_RREM:   rrem_r        <= pwdata[7:0];
        vsd_pkg::IDX_PKT:    pkt_r         <= pwdata[PKT_W-1:0];
        vsd_pkg::IDX_DCMD: begin
          // Settings are frozen while a transfer runs
          if (!dma_busy) begin
            dcmd_r <= {pwdata[vsd_pkg::DC_D64], pwdata[vsd_pkg::DC_WRITE],
                       pwdata[vsd_pkg::DC_PAUSE], pwdata[vsd_pkg::DC_IEN],
                       1'b0, pwdata[vsd_pkg::DC_BLOCK]};
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign send_pt = wr & (idx == vsd_pkg::IDX_LCMD) & pwdata[vsd_pkg::LCMD_SEND_PT] & ~dis_va_r;
  assign send_pr = wr & (idx == vsd_pkg::IDX_RCMD) & pwdata[vsd_pkg::RCMD_SEND_PR];

  // ----------------------------------------
  // Sticky status flags, a new event wins over a clear
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r <= '0;
    end else if (wr && idx == vsd_pkg::IDX_LCMD && pwdata[vsd_pkg::LCMD_CLR_ERR]) begin
      err_r <= err_in;
    end else begin
      err_r <= err_r | err_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pr_pend_r <= 1'b0;
    end else if (wr && idx == vsd_pkg::IDX_LCMD && pwdata[vsd_pkg::LCMD_CLR_PR]) begin
      pr_pend_r <= receiver_side_programmed_irq;
    end else begin
      pr_pend_r <= pr_pend_r | receiver_side_programmed_irq;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pt_pend_r <= 1'b0;
    end else if (wr && idx == vsd_pkg::IDX_RCMD && pwdata[vsd_pkg::RCMD_CLR_PT]) begin
      pt_pend_r <= transmitter_side_programmed_irq;
    end else begin
      pt_pend_r <= pt_pend_r | transmitter_side_programmed_irq;
    end
  end

  // Software clears done by writing the command word with bit 1 low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
    end else if (finish) begin
      done_r <= 1'b1;
    end else if (start) begin
      done_r <= 1'b0;
    end else if (wr && idx == vsd_pkg::IDX_DCMD) begin
      done_r <= done_r & pwdata[vsd_pkg::DC_DONE];
    end
  end

  assign irq_err      = (|err_r) & ~dis_av_r;
  assign irq_pr       = pr_pend_r & ~dis_av_r;
  assign irq_dma_done = done_r & dcmd_r[vsd_pkg::DC_IEN] & ~dis_av_r;

  // ----------------------------------------
  // Read data, latched in the setup cycle
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      unique case (idx)
        vsd_pkg::IDX_LCMD: begin
          prdata[vsd_pkg::LCMD_DIS_VA] <= dis_va_r;
          prdata[vsd_pkg::LCMD_DIS_AV] <= dis_av_r;
        end
        vsd_pkg::IDX_LSTAT: begin
          prdata[vsd_pkg::LST_PAR]  <= err_r.parity;
          prdata[vsd_pkg::LST_LRC]  <= err_r.longitudinal_redundancy_check;
          prdata[vsd_pkg::LST_TMO]  <= err_r.timeout;
          prdata[vsd_pkg::LST_RBUS] <= err_r.rbus;
          prdata[vsd_pkg::LST_PR]   <= pr_pend_r;
        end
        vsd_pkg::IDX_RSTAT:  prdata[vsd_pkg::RST_PT] <= pt_pend_r;
        vsd_pkg::IDX_AMOD:   prdata[7:0]   <= addr_modifier;
        vsd_pkg::IDX_IVEC:   prdata[7:0]   <= irq_vector;
        vsd_pkg::IDX_FWD:    prdata[7:1]   <= fwd_mask_r;
        vsd_pkg::IDX_LDADDR: prdata        <= ldaddr_r;
        vsd_pkg::IDX_RDADDR: prdata[23:0]  <= rdaddr_r;
        vsd_pkg::IDX_LREM:   prdata[7:0]   <= lrem_r;
        vsd_pkg::IDX_RREM:   prdata[7:0]   <= rrem_r;
        vsd_pkg::IDX_PKT:    prdata[PKT_W-1:0] <= pkt_r;
        vsd_pkg::IDX_DCMD: begin
          prdata[5:0]               <= dcmd_r;
          prdata[vsd_pkg::DC_DONE]  <= done_r;
          prdata[vsd_pkg::DC_START] <= dma_busy;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // DMA engine
  // ----------------------------------------
  // A start written while either side is busy is dropped, not queued
  assign start = wr & (idx == vsd_pkg::IDX_DCMD) & pwdata[vsd_pkg::DC_START] &
                 ~dma_busy & ~remote_dma_busy;
  assign dma_busy = (state_r != vsd_pkg::ST_IDLE);

  assign beat_full = dcmd_r[vsd_pkg::DC_D64] ? vsd_pkg::BEAT_D64 : vsd_pkg::BEAT_D32;
  assign beat      = (bytes_left_r < BL_W'(beat_full)) ? bytes_left_r[3:0] : beat_full;
  assign last_beat = (bytes_left_r == BL_W'(beat));
  assign limit     = dcmd_r[vsd_pkg::DC_PAUSE] ? vsd_pkg::LIM_PAUSE :
                     dcmd_r[vsd_pkg::DC_D64]   ? vsd_pkg::LIM_D64 : vsd_pkg::LIM_D32;
  assign tenure_end = ~dcmd_r[vsd_pkg::DC_BLOCK] |
                      ((tenure_r + 10'(beat) + 10'(beat_full)) > limit);
  assign finish = (start && pkt_r == '0 && lrem_r == 8'h00) ||
                  (state_r == vsd_pkg::ST_XFER && (vme_err || (vme_ack && last_beat)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= vsd_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        vsd_pkg::ST_IDLE: begin
          if (start && !finish) state_r <= vsd_pkg::ST_ARB;
        end
        vsd_pkg::ST_ARB: begin
          if (vme_bus_grant) state_r <= vsd_pkg::ST_XFER;
        end
        vsd_pkg::ST_XFER: begin
          if (finish) begin
            state_r <= vsd_pkg::ST_IDLE;
          end else if (vme_ack && tenure_end) begin
            state_r <= vsd_pkg::ST_REL;
          end
        end
        vsd_pkg::ST_REL: state_r <= vsd_pkg::ST_ARB;
      endcase
    end
  end

  // Packets and remainder form one byte count, so packets go first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bytes_left_r <= '0;
      vme_req      <= '0;
      remote_addr  <= 24'h00_0000;
    end else if (start) begin
      bytes_left_r      <= {pkt_r, lrem_r};
      vme_req.addr      <= ldaddr_r;
      // Settings of the start word itself, as they load into the command register too
      vme_req.write     <= pwdata[vsd_pkg::DC_WRITE];
      vme_req.d64       <= pwdata[vsd_pkg::DC_D64];
      remote_addr       <= rdaddr_r;
    end else if (state_r == vsd_pkg::ST_XFER && vme_ack) begin
      bytes_left_r <= bytes_left_r - BL_W'(beat);
      vme_req.addr <= vme_req.addr + 32'(beat);
      remote_addr  <= remote_addr + 24'(beat);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tenure_r <= 10'h000;
    end else if (state_r != vsd_pkg::ST_XFER) begin
      tenure_r <= 10'h000;
    end else if (vme_ack) begin
      tenure_r <= tenure_r + 10'(beat);
    end
  end

  assign vme_bus_req   = (state_r == vsd_pkg::ST_ARB) || (state_r == vsd_pkg::ST_XFER);
  assign vme_req_valid = (state_r == vsd_pkg::ST_XFER);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_err_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && idx == vsd_pkg::IDX_LCMD && pwdata[vsd_pkg::LCMD_CLR_ERR] && err_in == '0)
      |=> (err_r == '0)) else $error("error flags not cleared");
  a_pr_flag: assert property (@(posedge pclk) disable iff (!presetn)
    receiver_side_programmed_irq |=> pr_pend_r) else $error("receiver flag lost");
  a_pt_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && idx == vsd_pkg::IDX_RCMD && pwdata[vsd_pkg::RCMD_CLR_PT] &&
     !transmitter_side_programmed_irq) |=> !pt_pend_r) else $error("pt flag not cleared");
  a_block_irq: assert property (@(posedge pclk) disable iff (!presetn)
    dis_av_r |-> !(irq_err || irq_pr || irq_dma_done)) else $error("irq not blocked");
  a_done_irq: assert property (@(posedge pclk) disable iff (!presetn)
    !(done_r && dcmd_r[vsd_pkg::DC_IEN]) |-> !irq_dma_done) else $error("done irq without done");
  a_fwd_gate: assert property (@(posedge pclk) disable iff (!presetn)
    $past(dis_va_r) |-> (cable_interrupt_line == 7'h00)) else $error("forwarding not gated");
  a_one_xfer: assert property (@(posedge pclk) disable iff (!presetn)
    (!dma_busy && remote_dma_busy) |=> !dma_busy) else $error("start while remote busy");
  a_first_addr: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(dma_busy) |-> (vme_req.addr == ldaddr_r && remote_addr == rdaddr_r))
    else $error("wrong start address");
  a_nonblock: assert property (@(posedge pclk) disable iff (!presetn)
    (vme_req_valid && vme_ack && !dcmd_r[vsd_pkg::DC_BLOCK]) |=> !vme_bus_req)
    else $error("bus kept in non-block mode");
  a_tenure_lim: assert property (@(posedge pclk) disable iff (!presetn)
    dma_busy |-> (tenure_r <= limit)) else $error("tenure over limit");
  a_done_end: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(dma_busy) |-> done_r) else $error("done not set at end");
  a_count_down: assert property (@(posedge pclk) disable iff (!presetn)
    (vme_req_valid && vme_ack) |=>
      (bytes_left_r == $past(bytes_left_r) - BL_W'($past(beat)))) else $error("bad count");
endmodule

// [testbench/vsd_vme_partner.sv]
/*
  VMEbus arbiter and slave model facing the DMA block.
  Assumes grant, request and answers are sampled on rising pclk edges.
*/
`timescale 1ns/100ps
module vsd_vme_partner (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     slow,
  input  wire logic                     clr,
  input  wire logic [7:0]               err_at,
  input  wire logic                     vme_bus_req,
  input  wire logic                     vme_req_valid,
  input  wire vsd_pkg::vsd_vme_req_type vme_req,
  output logic                          vme_bus_grant,
  output logic                          vme_ack,
  output logic                          vme_err,
  output logic      [15:0]              n_acks,
  output logic      [7:0]               max_beats,
  output logic      [31:0]              first_addr
);
  logic [1:0] wait_r;
  logic [7:0] beats_r;
  // ----------------------------------------
  // Arbiter and slave
  // ----------------------------------------
  // Slow mode holds off grant, and each answer but the first of a tenure, by three cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vme_bus_grant <= 1'b0;
      vme_ack       <= 1'b0;
      vme_err       <= 1'b0;
      wait_r        <= 2'h0;
    end else begin
      vme_ack <= 1'b0;
      vme_err <= 1'b0;
      if (!vme_bus_req) begin
        vme_bus_grant <= 1'b0;
        wait_r        <= 2'h0;
      end else if (slow && wait_r != 2'h3) begin
        wait_r <= wait_r + 2'h1;
      end else if (!vme_bus_grant) begin
        vme_bus_grant <= 1'b1;
      end else if (vme_req_valid && !vme_ack && !vme_err) begin
        vme_ack <= (n_acks[7:0] + 8'h01) != err_at;
        vme_err <= (n_acks[7:0] + 8'h01) == err_at;
        wait_r  <= 2'h0;
      end
    end
  end
  // ----------------------------------------
  // Tenure statistics for the bench
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_acks     <= 16'h0;
      max_beats  <= 8'h0;
      first_addr <= 32'h0;
      beats_r    <= 8'h0;
    end else if (clr) begin
      n_acks     <= 16'h0;
      max_beats  <= 8'h0;
      first_addr <= 32'h0;
      beats_r    <= 8'h0;
    end else if (!vme_bus_req) begin
      beats_r <= 8'h0;
    end else if (vme_ack) begin
      if (n_acks == 16'h0) first_addr <= vme_req.addr;
      n_acks  <= n_acks + 16'h1;
      beats_r <= beats_r + 8'h1;
      if (beats_r + 8'h1 > max_beats) max_beats <= beats_r + 8'h1;
    end
  end
endmodule

// [testbench/testbench.sv]
/*
  Self-checking bench of the DMA and interrupt forwarding block.
  Assumes a 200 MHz pclk and the zero-wait APB slave of the design.
*/
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic [5:0]  idx;
    logic [31:0] wd;
    logic [31:0] exp;
  } vsd_row_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q, rx_irq, tx_irq;
  logic send_pt, send_pr, irq_err, irq_pr, irq_dma_done, remote_dma_busy, dma_busy, slow, clr;
  logic vme_bus_req, vme_bus_grant, vme_req_valid, vme_ack, vme_err;
  logic [7:0] paddr, addr_modifier, irq_vector, err_at, max_beats;
  logic [31:0] pwdata, prdata, rd_q, first_addr;
  logic [7:1] vme_irq_n, cable_interrupt_line;
  logic [23:0] remote_addr;
  logic [15:0] n_acks;
  vsd_pkg::vsd_err_type err_in;
  vsd_pkg::vsd_vme_req_type vme_req;
  int n_errors, n_checks;
  int n_pt = 0;
  int n_pr = 0;
  vsd_row_type rows [0:6] = '{
    '{vsd_pkg::IDX_AMOD, 32'h0000_00A5, 32'h0000_00A5},
    '{vsd_pkg::IDX_IVEC, 32'h0000_005A, 32'h0000_005A},
    '{vsd_pkg::IDX_LDADDR, 32'h89AB_CDEF, 32'h89AB_CDEF},
    '{vsd_pkg::IDX_RDADDR, 32'hFFFF_FFFF, 32'h00FF_FFFF},
    '{vsd_pkg::IDX_LREM, 32'h0000_01FF, 32'h0000_00FF},
    '{vsd_pkg::IDX_PKT, 32'h0001_2345, 32'h0000_2345},
    '{vsd_pkg::IDX_FWD, 32'h0000_00FF, 32'h0000_00FE}};

  vsd_dma vsd_dma_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vme_irq_n(vme_irq_n), .cable_interrupt_line(cable_interrupt_line),
    .err_in(err_in), .receiver_side_programmed_irq(rx_irq),
    .transmitter_side_programmed_irq(tx_irq), .send_pt(send_pt), .send_pr(send_pr),
    .irq_err(irq_err), .irq_pr(irq_pr), .irq_dma_done(irq_dma_done),
    .addr_modifier(addr_modifier), .irq_vector(irq_vector), .remote_dma_busy(remote_dma_busy),
    .dma_busy(dma_busy), .vme_bus_req(vme_bus_req), .vme_bus_grant(vme_bus_grant),
    .vme_req_valid(vme_req_valid), .vme_req(vme_req), .vme_ack(vme_ack), .vme_err(vme_err),
    .remote_addr(remote_addr));
  vsd_vme_partner vsd_vme_partner_inst (.pclk(pclk), .presetn(presetn), .slow(slow),
    .clr(clr), .err_at(err_at), .vme_bus_req(vme_bus_req), .vme_req_valid(vme_req_valid),
    .vme_req(vme_req), .vme_bus_grant(vme_bus_grant), .vme_ack(vme_ack), .vme_err(vme_err),
    .n_acks(n_acks), .max_beats(max_beats), .first_addr(first_addr));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Send pulses last one cycle only, so count them at every edge
  always @(posedge pclk) begin
    n_pt <= n_pt + int'(send_pt);
    n_pr <= n_pr + int'(send_pr);
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_errors++;
      close_out();
    end
    rd_q    = prdata;
    err_q   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd_q, exp);
  endtask
  // Programs a transfer from local address 0x1000 and checks what the slave saw
  task automatic dma(input logic [7:0] cmd, input logic [15:0] len, input logic [7:0] mb,
                     input logic [15:0] beats);
    int i;
    clr <= 1'b1;
    apb(1'b1, vsd_pkg::IDX_DCMD, {24'h0, cmd});
    clr <= 1'b0;
    apb(1'b1, vsd_pkg::IDX_LDADDR, 32'h0000_1000);
    apb(1'b1, vsd_pkg::IDX_LREM, {24'h0, len[7:0]});
    apb(1'b1, vsd_pkg::IDX_RREM, {24'h0, len[7:0]});
    apb(1'b1, vsd_pkg::IDX_PKT, {24'h0, len[15:8]});
    apb(1'b1, vsd_pkg::IDX_DCMD, {24'h0, cmd | 8'h80});
    tick(2);
    for (i = 0; i < 4000 && dma_busy !== 1'b0; i++) @(posedge pclk);
    if (i == 4000) begin
      n_errors++;
      close_out();
    end
    chk(n_acks, beats);
    chk(max_beats, mb);
    chk(first_addr, 32'h0000_1000);
    rdc(vsd_pkg::IDX_DCMD, {24'h0, cmd | 8'h02});
    chk(irq_dma_done, cmd[2]);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, rx_irq, tx_irq, remote_dma_busy, slow, clr} = 8'h00;
    {paddr, pwdata, err_at, err_in} = '0;
    vme_irq_n = 7'h7F;
    presetn   = 1'b0;
    n_errors  = 0;
    n_checks  = 0;
    tick(8);
    presetn <= 1'b1;
    rdc(vsd_pkg::IDX_DCMD, 32'h0);
    rdc(vsd_pkg::IDX_LSTAT, 32'h0);
    apb(1'b0, 6'h02, 32'h0);
    chk(err_q, 1'b1);
    chk(rd_q, 32'h0);
    foreach (rows[k]) begin
      apb(1'b1, rows[k].idx, rows[k].wd);
      rdc(rows[k].idx, rows[k].exp);
    end
    chk({addr_modifier, irq_vector}, 32'h0000_A55A);
    err_in <= '1;
    tick(1);
    err_in <= '0;
    rdc(vsd_pkg::IDX_LSTAT, 32'h0000_00CC);
    chk(irq_err, 1'b1);
    apb(1'b1, vsd_pkg::IDX_LCMD, 32'h0000_0080);
    rdc(vsd_pkg::IDX_LSTAT, 32'h0);
    rx_irq <= 1'b1;
    tick(1);
    rx_irq <= 1'b0;
    rdc(vsd_pkg::IDX_LSTAT, 32'h0000_0020);
    chk(irq_pr, 1'b1);
    apb(1'b1, vsd_pkg::IDX_LCMD, 32'h0000_0010);
    tick(1);
    chk(irq_pr, 1'b0);
    apb(1'b1, vsd_pkg::IDX_LCMD, 32'h0000_0040);
    rdc(vsd_pkg::IDX_LSTAT, 32'h0);
    tx_irq <= 1'b1;
    tick(1);
    tx_irq <= 1'b0;
    rdc(vsd_pkg::IDX_RSTAT, 32'h0000_0002);
    apb(1'b1, vsd_pkg::IDX_RCMD, 32'h0000_0040);
    rdc(vsd_pkg::IDX_RSTAT, 32'h0);
    apb(1'b1, vsd_pkg::IDX_LCMD, 32'h0000_0020);
    apb(1'b1, vsd_pkg::IDX_RCMD, 32'h0000_0020);
    // Levels 5 and 6 forwarded; level 3 is low but not selected
    apb(1'b1, vsd_pkg::IDX_FWD, 32'h0000_0060);
    vme_irq_n <= 7'b1001011;
    tick(6);
    chk(cable_interrupt_line, 7'b0110000);
    apb(1'b1, vsd_pkg::IDX_LCMD, 32'h0000_0004);
    tick(3);
    chk(cable_interrupt_line, 7'h00);
    // A send request is held back while interrupt passing is disabled
    apb(1'b1, vsd_pkg::IDX_LCMD, 32'h0000_0024);
    chk({n_pr[15:0], n_pt[15:0]}, 32'h0001_0001);
    vme_irq_n <= 7'h7F;
    err_at <= 8'h02;
    dma(8'h00, 16'h0010, 8'h01, 16'h0001);
    err_at <= 8'h00;
    dma(8'h00, 16'h0008, 8'h01, 16'h0002);
    dma(8'h09, 16'h010A, 8'h10, 16'h0043);
    slow <= 1'b1;
    dma(8'h01, 16'h0300, 8'h40, 16'h00C0);
    slow <= 1'b0;
    dma(8'h35, 16'h0400, 8'h40, 16'h0080);
    chk(remote_addr, 32'h0000_03FF);
    chk({vme_req.write, vme_req.d64, vme_req.addr[29:0]}, 32'hC000_1400);
    apb(1'b1, vsd_pkg::IDX_LCMD, 32'h0000_0014);
    tick(1);
    chk(irq_dma_done, 1'b0);
    remote_dma_busy <= 1'b1;
    apb(1'b1, vsd_pkg::IDX_DCMD, 32'h0000_0081);
    tick(3);
    chk(dma_busy, 1'b0);
    remote_dma_busy <= 1'b0;
    apb(1'b1, vsd_pkg::IDX_DCMD, 32'h0);
    rdc(vsd_pkg::IDX_DCMD, 32'h0);
    close_out();
  end
endmodule
